// file: src/ssc_bank.v
/*
 * Register bank for sequencer steps five and six of the auxiliary
 * converter, with decoded routing outputs for step five; step six drives bit 1 of o_step5_enable and o_step5_internal and a folded o_step6_pad summary.
 * Assumes the host port delivers decoded address, write strobe and
 * read strobe synchronous to i_sys_clk; read data is registered.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"
module ssc_bank (
    input wire i_sys_clk,
    input wire i_rst,
    input wire [7:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] i_wdata,
    output reg [15:0] o_rdata,
    output reg o_rvalid,
    output reg o_hit,
    output reg [1:0] o_step5_enable,
    output reg [1:0] o_step5_gain_select,
    output reg [1:0] o_step5_neg_input_select,
    output reg [3:0] o_step5_pos_input_select,
    output reg [1:0] o_step5_internal,
    output reg [1:0] o_step6_pad
);
    // Index 0 is step five, index 1 is step six
    wire [31:0] cfg_flat;
    wire [7:0] step_addr [0:1];
    wire [1:0] gain_w [0:1];
    wire [1:0] neg_w [0:1];
    wire [3:0] pos_w [0:1];
    wire [1:0] int_w;
    reg [15:0] rdata_next;
    reg hit_next;
    assign step_addr[0] = `SSC_ADDR_STEP5;
    assign step_addr[1] = `SSC_ADDR_STEP6;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_step
            ssc_step_reg #(
                .RST_VALUE(g == 0 ? `SSC_RST_STEP5 : `SSC_RST_STEP6)
            ) u_reg (
                .i_sys_clk(i_sys_clk),
                .i_rst(i_rst),
                .i_wr(i_wr && (i_addr == step_addr[g])),
                .i_wdata(i_wdata),
                .o_value(cfg_flat[16*g+15:16*g])
            );
            ssc_route u_route (
                .i_cfg(cfg_flat[16*g+15:16*g]),
                .o_gain(gain_w[g]),
                .o_neg_sel(neg_w[g]),
                .o_pos_sel(pos_w[g]),
                .o_internal(int_w[g])
            );
        end
    endgenerate
    always @*
    begin
        rdata_next = `SSC_ZERO16;
        hit_next = 1'b0;
        if (i_addr == `SSC_ADDR_STEP5)
        begin
            rdata_next = cfg_flat[15:0];
            hit_next = 1'b1;
        end
        else if (i_addr == `SSC_ADDR_STEP6)
        begin
            rdata_next = cfg_flat[31:16];
            hit_next = 1'b1;
        end
    end
    // Outputs registered so routing follows a write by one cycle
    always @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_rdata <= `SSC_ZERO16;
            o_rvalid <= 1'b0;
            o_hit <= 1'b0;
            o_step5_enable <= 2'b00;
            o_step5_gain_select <= `SSC_GAIN_X1;
            o_step5_neg_input_select <= `SSC_NEG_GND;
            o_step5_pos_input_select <= `SSC_RST_POS5;
            o_step5_internal <= 2'b00;
            o_step6_pad <= 2'b00;
        end
        else
        begin
            o_rvalid <= i_rd;
            o_hit <= i_rd && hit_next;
            if (i_rd)
                o_rdata <= rdata_next;
            o_step5_enable <= {cfg_flat[16+`SSC_EN_BIT],
                cfg_flat[`SSC_EN_BIT]};
            o_step5_gain_select <= gain_w[0];
            o_step5_neg_input_select <= neg_w[0];
            o_step5_pos_input_select <= pos_w[0];
            o_step5_internal <= int_w;
            o_step6_pad <= gain_w[1] ^ neg_w[1] ^ {2{|pos_w[1]}};
        end
    end
endmodule
`default_nettype wire

// file: pkg/ssc_consts.vh
/*
 * Constants for the sequencer step configuration register bank:
 * addresses, field positions, reset values and input-routing codes.
 * Assumes a simple synchronous word port on the device side.
 */
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH

`define SSC_ADDR_W 8
`define SSC_DATA_W 16
`define SSC_ADDR_STEP5 8'h95
`define SSC_ADDR_STEP6 8'h96
`define SSC_RST_STEP5 16'h0005
`define SSC_RST_STEP6 16'h0006
`define SSC_RST_POS5 4'h5
`define SSC_EN_BIT 15
`define SSC_GAIN_HI 14
`define SSC_GAIN_LO 13
`define SSC_NEG_BIT 4
`define SSC_POS_HI 3
`define SSC_POS_LO 0
`define SSC_WR_MASK 16'hE01F
`define SSC_ZERO16 16'h0000
`define SSC_GAIN_X1 2'h0
`define SSC_GAIN_X2 2'h1
`define SSC_GAIN_X4 2'h2
`define SSC_POS_TEMP 4'h8
`define SSC_POS_SHORT 4'h9
`define SSC_POS_TEST 4'hA
`define SSC_NEG_GND 2'h0
`define SSC_NEG_IN7 2'h1
`define SSC_NEG_AUTO 2'h2

`endif

// file: src/ssc_step_reg.v
/*
 * One step configuration register with reserved bits held at zero.
 * Assumes writes are single-cycle strobes in the i_sys_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"
module ssc_step_reg #(
    parameter [15:0] RST_VALUE = 16'h0000
)
(
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_wr,
    input wire [15:0] i_wdata,
    output wire [15:0] o_value
);
    reg [15:0] value_reg;
    always @(posedge i_sys_clk)
    begin
        if (i_rst)
            value_reg <= RST_VALUE;
        else if (i_wr)
            value_reg <= i_wdata & `SSC_WR_MASK;
    end
    assign o_value = value_reg & `SSC_WR_MASK;
endmodule
`default_nettype wire

// file: src/ssc_route.v
/*
 * Decodes a step word into gain and input routing selections.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"
module ssc_route (
    input wire [15:0] i_cfg,
    output reg [1:0] o_gain,
    output reg [1:0] o_neg_sel,
    output reg [3:0] o_pos_sel,
    output reg o_internal
);
    always @*
    begin
        o_pos_sel = i_cfg[`SSC_POS_HI:`SSC_POS_LO];
        o_internal = i_cfg[`SSC_POS_HI];
        case (i_cfg[`SSC_GAIN_HI:`SSC_GAIN_LO])
            `SSC_GAIN_X1: o_gain = `SSC_GAIN_X1;
            `SSC_GAIN_X2: o_gain = `SSC_GAIN_X2;
            default: o_gain = `SSC_GAIN_X4;
        endcase
        // Internal sources pick their own reference; bit 4 is a don't-care
        if (i_cfg[`SSC_POS_HI])
            o_neg_sel = `SSC_NEG_AUTO;
        else if (i_cfg[`SSC_NEG_BIT])
            o_neg_sel = `SSC_NEG_IN7;
        else
            o_neg_sel = `SSC_NEG_GND;
    end
endmodule
`default_nettype wire

// file: bench/ssc_bank_checker.sv
/* Checker for ssc_bank: read answers, reserved bits, step routing.
   Assumes it is bound to ssc_bank and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ssc_bank_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_hit,
    input wire logic [1:0] o_step5_enable,
    input wire logic [1:0] o_step5_gain_select,
    input wire logic [1:0] o_step5_neg_input_select,
    input wire logic [3:0] o_step5_pos_input_select,
    input wire logic [1:0] o_step5_internal
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence s_wr5;
        i_wr && i_addr == 8'h95;
    endsequence
    sequence s_rd_map;
        i_rd && (i_addr == 8'h95 || i_addr == 8'h96);
    endsequence
    map_hit_a: assert property (s_rd_map |=> o_rvalid && o_hit)
        else $error("mapped read missed");
    miss_zero_a: assert property (i_rd && i_addr != 8'h95 &&
        i_addr != 8'h96 |=> o_rvalid && !o_hit && o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    rsvd_zero_a: assert property (o_rvalid |-> o_rdata[12:5] == 8'h00)
        else $error("reserved bits set");
    wr_enable_a: assert property (s_wr5 |-> ##2
        o_step5_enable[0] == $past(i_wdata[15], 2))
        else $error("enable not updated");
    wr_pos_a: assert property (s_wr5 |-> ##2
        o_step5_pos_input_select == $past(i_wdata[3:0], 2))
        else $error("positive select wrong");
    wr_gain_a: assert property (s_wr5 |-> ##2 o_step5_gain_select ==
        ($past(i_wdata[14], 2) ? 2'h2 : {1'b0, $past(i_wdata[13], 2)}))
        else $error("gain code wrong");
    auto_neg_a: assert property (o_step5_pos_input_select[3] |->
        o_step5_neg_input_select == 2'h2)
        else $error("negative input not automatic");
    internal_src_a: assert property (o_step5_internal[0] ==
        o_step5_pos_input_select[3])
        else $error("internal flag wrong");
endmodule
`default_nettype wire

// file: bench/ssc_bank_tb.sv
/* Bench for ssc_bank: register reads, writes and step routing.
   Assumes the checker is compiled first and bound below. */
`timescale 1ns/1ps
`default_nettype none
module ssc_bank_tb;
    logic clk = 0;
    logic rst = 1;
    logic wr = 0;
    logic rd = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wd = 16'h0000;
    wire [15:0] rdata;
    wire rvalid, hit;
    wire [1:0] en, gain, neg, intl, pad;
    wire [3:0] pos;
    int err_count = 0;
    int samples_checked = 0;
    ssc_bank ssc_bank_inst (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_hit(hit), .o_step5_enable(en),
        .o_step5_gain_select(gain), .o_step5_neg_input_select(neg),
        .o_step5_pos_input_select(pos), .o_step5_internal(intl),
        .o_step6_pad(pad));
    initial forever #2.5 clk = ~clk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e,
        input logic h);
        int n;
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        for (n = 0; n < 3 && rvalid !== 1'b1; n++)
            @(negedge clk);
        if (n == 3)
        begin
            err_count++;
            complete_run();
        end
        else
        begin
            check(rdata, e);
            check(16'(hit), 16'(h));
        end
    endtask
    // Writes ones into the reserved field too, so masking is exercised
    task automatic route(input logic [15:0] d);
        logic [15:0] v;
        v = 16'({d[15], d[14] ? 2'h2 : {1'b0, d[13]},
            d[3] ? 2'h2 : {1'b0, d[4]}, d[3:0], d[3]});
        wr_reg(8'h95, d);
        rd_reg(8'h95, d & 16'hE01F, 1'b1);
        check(16'({en[0], gain, neg, pos, intl[0]}), v);
    endtask
    initial
    begin
        int k;
        repeat (6) @(negedge clk);
        rst = 0;
        rd_reg(8'h95, 16'h0005, 1'b1);
        rd_reg(8'h96, 16'h0006, 1'b1);
        rd_reg(8'h94, 16'h0000, 1'b0);
        check(16'({en, gain, neg, pos, intl}), 16'h0014);
        $display("reset test done");
        for (k = 0; k < 32; k++)
            route({k[0], k[2:1], 8'hFF, k[4], k[3:0]});
        $display("routing test done");
        wr_reg(8'h96, 16'h9FE3);
        wr_reg(8'h97, 16'hFFFF);
        rd_reg(8'h96, 16'h8003, 1'b1);
        rd_reg(8'h97, 16'h0000, 1'b0);
        check(16'(en[1]), 16'h0001);
        // Summary is gain code ^ negative code ^ (positive code nonzero)
        check(16'({en[1], intl[1], pad}), 16'h000B);
        wr_reg(8'h96, 16'h4019);
        rd_reg(8'h96, 16'h4019, 1'b1);
        check(16'({en[1], intl[1], pad}), 16'h0007);
        $display("step six test done");
        complete_run();
    end
endmodule
bind ssc_bank ssc_bank_checker ssc_bank_checker_inst (.*);
`default_nettype wire
